/* battery_pin_pkg.sv */
/*
  Shared constants and types for the eight-pin battery I/O controller.
  Assumes a 125 MHz aclk and an AXI4-Lite register bus with 8-bit addresses.
*/
package battery_pin_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 125_000_000;
  localparam int DISPLAY_BASE_MS = 2000;
  localparam int DISPLAY_BASE_CYCLES = DISPLAY_BASE_MS * (CLK_HZ / 1000);
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_PIN_CFG = 8'h00;
  localparam logic [7:0] OFS_PIN_ASG = 8'h04;
  localparam logic [7:0] OFS_LED_CFG = 8'h08;
  localparam logic [7:0] OFS_PERM    = 8'h0C;
  localparam logic [7:0] OFS_LVL     = 8'h10; // four words, two levels each
  localparam logic [7:0] OFS_CDEF    = 8'h20; // four words, two pins each
  localparam logic [7:0] OFS_STATUS  = 8'h30;
  localparam logic [7:0] OFS_MASK    = 8'h34;
  localparam logic [7:0] OFS_PINSTAT = 8'h38;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // fault indices and status bits
  // ----------------------------------------------------------------
  localparam int FLT_IMB = 0, FLT_OT = 1, FLT_OC = 2, FLT_COV = 3;
  localparam int FLT_POV = 4, FLT_UT = 5, FLT_CUV = 6, LVL_ALARM = 7;
  localparam int ST_DISP = 8, ST_FAULT = 9, ST_ALARM = 10, STAT_W = 11;
  localparam int PERM_EN_BIT = 16;
  // ----------------------------------------------------------------
  // types; first field of a word is its high byte
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] pin_active_level, soc_display_membership;
    logic [7:0] pin_direction_select, pin_function_select;
  } pin_cfg_t;
  typedef struct packed {
    logic [7:0] charge_pin_assign, display_switch_assign;
    logic [7:0] safety_pin_assign, pin_powerup_state;
  } pin_asg_t;
  typedef struct packed {
    logic [7:0] voltage_fault_filter_count, current_fault_filter_count;
    logic [7:0] display_extend_count, led_pwm_duty;
  } led_cfg_t;
  typedef struct packed {
    logic [15:0] imbalance, temp, current, cell_max, pack, cell_min;
  } meas_t;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam pin_cfg_t PIN_CFG_RST = '{8'hC0, 8'h1F, 8'hFF, 8'h00};
  localparam pin_asg_t PIN_ASG_RST = '{8'h00, 8'h00, 8'h60, 8'h00};
  localparam led_cfg_t LED_CFG_RST = '{8'h0A, 8'h3C, 8'h06, 8'h03};
  localparam logic [15:0] PERM_MIN_RST = 16'h0064;
  localparam logic [7:0][15:0] LVL_RST = '{16'h1004, 16'h0A8C, 16'h00C8,
    16'h41A0, 16'h1004, 16'h01F4, 16'h0258, 16'h0064};
  localparam logic [7:0][15:0] CDEF_RST = '{16'h0000, 16'h0001, 16'hAE00,
    16'h0051, 16'h003D, 16'h0029, 16'h0015, 16'h0001};
  // ----------------------------------------------------------------
  // whole state of the controller
  // ----------------------------------------------------------------
  typedef struct packed {
    pin_cfg_t pc; pin_asg_t pa; led_cfg_t lc;
    logic perm_en; logic [15:0] perm_min;
    logic [7:0][15:0] lvl, cdef;
    logic [STAT_W-1:0] status, mask;
    logic [7:0] pin_prev, pin_out; logic primed;
    logic [6:0] fault; logic alarm; logic [6:0][7:0] filt;
    logic [7:0] pwm; logic disp; logic [31:0] base_cnt; logic [7:0] ext_cnt;
    logic aw_got, w_got; logic [7:0] aw_addr; logic [31:0] wdata;
    logic [3:0] wstrb; logic bvalid; logic [1:0] bresp;
    logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } state_t;
endpackage : battery_pin_pkg

/* battery_pin_io_control.sv */
/*
  Eight programmable battery-manager pins: edge inputs, display switch,
  push-pull and LED outputs, safety and charge-control outputs, a timed
  state-of-charge display and filtered, threshold-cleared safety faults.
  Assumes synchronous pin inputs, a one-cycle period_tick from the device
  time base, and raw trip flags from the measurement logic.
*/
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
// Function
// - input edge sense set by function bit
// - output function bit selects LED or push-pull
// - direction bit one means output, default all
// - membership bit puts LED in charge display
// - triggered pin active, otherwise opposite level
// - polarity bit one means active high
// - reset drives power-up state level
// - safety bit hands pin to safety faults
// - switch bit makes pin the display switch
// - LED outputs modulated by stored duty
// - permanent display needs charging above minimum
// - display lasts two seconds plus periods
// - current fault needs filter periods held
// - voltage fault needs filter periods held
// - clear levels release matching safety faults
// - separate level clears charge stop alarm
// - condition word: low AND, high OR
// - charge bit drives pin from charge control
`timescale 1ns/1ns
module battery_pin_io_control #(
  parameter int HOLD_CYCLES = battery_pin_pkg::DISPLAY_BASE_CYCLES
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          ce,
  input  wire logic [7:0]                    awaddr,
  input  wire logic                          awvalid,
  output      logic                          awready,
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output      logic                          wready,
  output      logic [1:0]                    bresp,
  output      logic                          bvalid,
  input  wire logic                          bready,
  input  wire logic [7:0]                    araddr,
  input  wire logic                          arvalid,
  output      logic                          arready,
  output      logic [31:0]                   rdata,
  output      logic [1:0]                    rresp,
  output      logic                          rvalid,
  input  wire logic                          rready,
  input  wire logic [7:0]                    pin_i,
  output      logic [7:0]                    pin_o,
  output      logic [7:0]                    pin_oe,
  input  wire logic                          period_tick,
  input  wire logic [6:0]                    trip_raw,
  input  wire logic                          charge_alarm_set,
  input  wire logic                          charging,
  input  wire logic                          charge_req,
  input  wire logic [3:0]                    ext_cond,
  input  wire battery_pin_pkg::meas_t        meas,
  output      logic                          irq
);
  import battery_pin_pkg::*;

  state_t st;
  state_t next_st;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // and-group needs a non-empty mask, or an empty AND would always fire
  function automatic logic cond_hit(logic [15:0] def, logic [7:0] c);
    logic [7:0] am;
    am = def[7:0];
    return ((am != 8'h00) && ((c & am) == am)) || |(c & def[15:8]);
  endfunction : cond_hit

  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n,
                                        logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = n[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic mapped(logic [7:0] a);
    return a[7:2] <= OFS_PINSTAT[7:2];
  endfunction : mapped

  function automatic logic [31:0] rd_word(state_t s, logic [7:0] a);
    logic [31:0] r;
    logic [1:0]  k;
    r = 32'h0000_0000;
    k = a[3:2];
    if (a[7:2] == OFS_PIN_CFG[7:2]) r = s.pc;
    if (a[7:2] == OFS_PIN_ASG[7:2]) r = s.pa;
    if (a[7:2] == OFS_LED_CFG[7:2]) r = s.lc;
    if (a[7:2] == OFS_PERM[7:2])    r = {15'h0000, s.perm_en, s.perm_min};
    if (a[7:4] == OFS_LVL[7:4])     r = {s.lvl[2*k+1], s.lvl[2*k]};
    if (a[7:4] == OFS_CDEF[7:4])    r = {s.cdef[2*k+1], s.cdef[2*k]};
    if (a[7:2] == OFS_STATUS[7:2])  r = 32'(s.status);
    if (a[7:2] == OFS_MASK[7:2])    r = 32'(s.mask);
    if (a[7:2] == OFS_PINSTAT[7:2]) r = {s.alarm, s.fault, 7'h00, s.disp,
                                         s.pin_out, s.pin_prev};
    return r;
  endfunction : rd_word

  // ----------------------------------------------------------------
  // pin decode
  // ----------------------------------------------------------------
  logic [7:0] is_out;
  logic [7:0] is_led;
  logic [7:0] rise;
  logic [7:0] fall;
  logic [7:0] edge_hit;
  logic [7:0] cond;
  logic [7:0] trig;
  logic       sw_hit;
  logic       perm_ok;
  logic       pwm_on;

  // a pin the switch owns is always listened to, never driven
  assign is_out = st.pc.pin_direction_select
                  & ~st.pa.display_switch_assign;
  assign is_led = is_out & st.pc.pin_function_select;
  assign pin_oe = is_out;
  assign pin_o  = st.pin_out;
  assign rise   = pin_i & ~st.pin_prev;
  assign fall   = ~pin_i & st.pin_prev;
  // first sample after reset has no history, so no edge is claimed
  assign edge_hit = st.primed ? (~is_out & ((st.pc.pin_function_select & rise)
                    | (~st.pc.pin_function_select & fall))) : 8'h00;
  assign sw_hit  = |(edge_hit & st.pa.display_switch_assign);
  assign perm_ok = st.perm_en && charging
                   && (meas.current >= st.perm_min);
  assign pwm_on  = st.pwm < st.lc.led_pwm_duty;
  assign cond    = {ext_cond, perm_ok, st.disp, st.alarm, |st.fault};

  // per-pin trigger: safety over charge control over LED and user logic
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (st.pa.safety_pin_assign[i]) begin
        trig[i] = |st.fault;
      end else if (st.pa.charge_pin_assign[i]) begin
        trig[i] = charge_req && !st.alarm;
      end else if (is_led[i] && st.pc.soc_display_membership[i]) begin
        trig[i] = (st.disp || perm_ok) && pwm_on;
      end else if (is_led[i]) begin
        trig[i] = cond_hit(st.cdef[i], cond) && pwm_on;
      end else begin
        trig[i] = cond_hit(st.cdef[i], cond);
      end
    end
  end

  // ----------------------------------------------------------------
  // safety clearing
  // ----------------------------------------------------------------
  logic [6:0] clr_ok;
  logic       alarm_clr;
  logic [7:0] lim [7];

  always_comb begin
    clr_ok[FLT_IMB] = meas.imbalance <= st.lvl[FLT_IMB];
    clr_ok[FLT_OT]  = meas.temp      <= st.lvl[FLT_OT];
    clr_ok[FLT_OC]  = meas.current   <= st.lvl[FLT_OC];
    clr_ok[FLT_COV] = meas.cell_max  <= st.lvl[FLT_COV];
    clr_ok[FLT_POV] = meas.pack      <= st.lvl[FLT_POV];
    clr_ok[FLT_UT]  = meas.temp      >= st.lvl[FLT_UT];
    clr_ok[FLT_CUV] = meas.cell_min  >= st.lvl[FLT_CUV];
  end
  assign alarm_clr = meas.cell_max <= st.lvl[LVL_ALARM];

  // only the current check uses the current filter; the rest use voltage
  generate
    for (genvar f = 0; f < 7; f++) begin : g_lim
      if (f == FLT_OC) begin : g_i
        assign lim[f] = st.lc.current_fault_filter_count;
      end else begin : g_v
        assign lim[f] = st.lc.voltage_fault_filter_count;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // bus handshakes; a frozen block accepts nothing
  // ----------------------------------------------------------------
  assign awready = ce && !st.aw_got && !st.bvalid;
  assign wready  = ce && !st.w_got && !st.bvalid;
  assign arready = ce && !st.rvalid;
  assign bvalid  = st.bvalid;
  assign bresp   = st.bresp;
  assign rvalid  = st.rvalid;
  assign rdata   = st.rdata;
  assign rresp   = st.rresp;
  assign irq     = |(st.status & st.mask);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0]       wv;
    logic [1:0]        k;
    logic [STAT_W-1:0] ev;
    logic [6:0]        nf;
    wv = 32'h0000_0000;
    k  = 2'h0;
    ev = '0;
    nf = st.fault;
    next_st = st;
    // write address and data are taken in either order
    if (awvalid && awready) begin
      next_st.aw_got  = 1'b1;
      next_st.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = wdata;
      next_st.wstrb = wstrb;
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_got && st.w_got) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = mapped(st.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      wv = merge(rd_word(st, st.aw_addr), st.wdata, st.wstrb);
      k  = st.aw_addr[3:2];
      if (st.aw_addr[7:2] == OFS_PIN_CFG[7:2]) next_st.pc = wv;
      if (st.aw_addr[7:2] == OFS_PIN_ASG[7:2]) next_st.pa = wv;
      if (st.aw_addr[7:2] == OFS_LED_CFG[7:2]) next_st.lc = wv;
      if (st.aw_addr[7:2] == OFS_PERM[7:2]) begin
        next_st.perm_en  = wv[PERM_EN_BIT];
        next_st.perm_min = wv[15:0];
      end
      if (st.aw_addr[7:4] == OFS_LVL[7:4]) begin
        next_st.lvl[2*k]   = wv[15:0];
        next_st.lvl[2*k+1] = wv[31:16];
      end
      if (st.aw_addr[7:4] == OFS_CDEF[7:4]) begin
        next_st.cdef[2*k]   = wv[15:0];
        next_st.cdef[2*k+1] = wv[31:16];
      end
      if (st.aw_addr[7:2] == OFS_STATUS[7:2]) begin
        next_st.status = st.status
                         & ~STAT_W'(merge(32'h0, st.wdata, st.wstrb));
      end
      if (st.aw_addr[7:2] == OFS_MASK[7:2]) begin
        next_st.mask = wv[STAT_W-1:0];
      end
    end
    // one read in flight; data is latched with the address
    if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_word(st, araddr);
      next_st.rresp  = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    // pin history and led modulation
    next_st.primed   = 1'b1;
    next_st.pin_prev = pin_i;
    next_st.pwm      = st.pwm + 8'h01;
    // display timer: fixed hold, then extension periods
    if (sw_hit && !st.disp) begin
      next_st.disp     = 1'b1;
      next_st.base_cnt = 32'(HOLD_CYCLES - 1);
      next_st.ext_cnt  = st.lc.display_extend_count;
      ev[ST_DISP]      = 1'b1;
    end else if (st.disp) begin
      if (st.base_cnt != 32'h0) begin
        next_st.base_cnt = st.base_cnt - 32'h1;
      end else if (st.ext_cnt != 8'h00) begin
        if (period_tick) begin
          next_st.ext_cnt = st.ext_cnt - 8'h01;
        end
      end else begin
        next_st.disp = 1'b0;
      end
    end
    // safety filters: a trip counts periods, a gap restarts it
    for (int f = 0; f < 7; f++) begin
      if (!trip_raw[f]) begin
        next_st.filt[f] = 8'h00;
      end else if (period_tick && st.filt[f] < lim[f]) begin
        next_st.filt[f] = st.filt[f] + 8'h01;
      end
      if (clr_ok[f] && !trip_raw[f]) begin
        nf[f] = 1'b0;
      end
      if (trip_raw[f] && st.filt[f] >= lim[f]) begin
        nf[f] = 1'b1;
      end
    end
    next_st.fault = nf;
    ev[ST_FAULT]  = |(nf & ~st.fault);
    // a new alarm outranks a clear in the same cycle
    if (alarm_clr) begin
      next_st.alarm = 1'b0;
    end
    if (charge_alarm_set) begin
      next_st.alarm = 1'b1;
    end
    ev[ST_ALARM] = charge_alarm_set && !st.alarm;
    ev[7:0]      = edge_hit;
    next_st.status = next_st.status | ev;
    // pins keep the power-up level for the first enabled cycle
    if (st.primed) begin
      next_st.pin_out = ~(trig ^ st.pc.pin_active_level);
    end else begin
      next_st.pin_out = st.pa.pin_powerup_state;
    end
  end

  // ----------------------------------------------------------------
  // state register; constants only under reset
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st          <= '0;
      st.pc       <= PIN_CFG_RST;
      st.pa       <= PIN_ASG_RST;
      st.lc       <= LED_CFG_RST;
      st.perm_min <= PERM_MIN_RST;
      st.lvl      <= LVL_RST;
      st.cdef     <= CDEF_RST;
      st.pin_out  <= PIN_ASG_RST.pin_powerup_state;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_start;
    ce && sw_hit && !st.disp;
  endsequence
  sequence s_lit;
    st.disp [*8];
  endsequence

  a_reset_level: assert property (disable iff (1'b0)
    !aresetn |=> pin_o == PIN_ASG_RST.pin_powerup_state)
    else $error("pins not at power-up level after reset");
  a_edge_catch: assert property (ce && edge_hit != 8'h00
    |=> (st.status[7:0] & $past(edge_hit)) == $past(edge_hit))
    else $error("input edge not recorded");
  a_drive_level: assert property (ce && st.primed
    |=> pin_o == ~($past(trig) ^ $past(st.pc.pin_active_level)))
    else $error("pin level does not follow trigger and polarity");
  a_display_start: assert property (s_start |=> s_lit)
    else $error("display did not start or ended early");
  a_display_ignore: assert property (ce && sw_hit && st.disp
    && st.base_cnt != 32'h0 |=> st.base_cnt == $past(st.base_cnt) - 32'h1)
    else $error("switch edge restarted running display");
  a_perm_gate: assert property (ce && st.primed && !st.disp && !charging
    && is_led[0] && st.pc.soc_display_membership[0] && !st.pa.safety_pin_assign[0]
    && !st.pa.charge_pin_assign[0] |=> pin_o[0] == ~$past(st.pc.pin_active_level[0]))
    else $error("permanent display without charge current");
  a_pwm_dark: assert property (ce && st.primed
    && st.lc.led_pwm_duty == 8'h00 && !st.pa.safety_pin_assign[0]
    && !st.pa.charge_pin_assign[0] && is_led[0]
    |=> pin_o[0] == ~$past(st.pc.pin_active_level[0]))
    else $error("led lit with zero duty");
  a_current_filter: assert property ($rose(st.fault[FLT_OC])
    |-> $past(st.filt[FLT_OC]) >= $past(st.lc.current_fault_filter_count))
    else $error("current fault raised before filter expired");
  a_voltage_filter: assert property ($rose(st.fault[FLT_COV])
    |-> $past(st.filt[FLT_COV]) >= $past(st.lc.voltage_fault_filter_count))
    else $error("voltage fault raised before filter expired");
  a_temp_clear: assert property (ce && st.fault[FLT_OT] && !trip_raw[FLT_OT]
    && meas.temp <= st.lvl[FLT_OT] |=> !st.fault[FLT_OT])
    else $error("overtemperature fault not cleared");
  a_alarm_clear: assert property (ce && st.alarm && !charge_alarm_set
    && meas.cell_max <= st.lvl[LVL_ALARM] |=> !st.alarm)
    else $error("charge stop alarm not cleared");
  a_safety_pin: assert property (ce && st.primed
    && st.pa.safety_pin_assign[5] |=> pin_o[5] ==
    ~($past(|st.fault) ^ $past(st.pc.pin_active_level[5])))
    else $error("safety pin not following faults");

endmodule : battery_pin_io_control

/* battery_pin_far_side.sv */
/*
  Far side of the battery pin controller: pins with pull-ups and one push switch.
  Assumes pin_oe high means the controller drives that pin.
*/
`timescale 1ns/1ns
module battery_pin_far_side #(
  parameter int SWITCH_BIT = 4
) (
  input  wire logic [7:0] pin_o,
  input  wire logic [7:0] pin_oe,
  input  wire logic       press,
  output      logic [7:0] pin_i
);
  // ----------------------------------------------------------------
  // wire levels
  // ----------------------------------------------------------------
  logic [7:0] pull_down;
  // a closed switch shorts its pin low; released pins float up to the pull-up
  assign pull_down = press ? (8'h01 << SWITCH_BIT) : 8'h00;
  // driven pins show the driver, undriven ones the pull-up unless switched
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ~pull_down);
endmodule : battery_pin_far_side

/* battery_pin_io_control_bench.sv */
/*
  Self-checking bench for the battery pin controller: register reset values,
  polarity, safety filtering and clearing, switch-started display and interrupt.
  Assumes the far-side model has its push switch on pin 4.
*/
`timescale 1ns/1ns
module battery_pin_io_control_bench;
  import battery_pin_pkg::*;
  typedef struct packed { logic [7:0] a; logic [31:0] d; logic [1:0] r; } row_t;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, period_tick, irq, press, ce, charge_alarm_set;
  logic [7:0]  awaddr, araddr, pin_i, pin_o, pin_oe;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic [6:0]  trip_raw;
  meas_t       meas;
  int          error_cnt, comparisons;
  // reads of every register but status and pin status right after reset; the last row is unmapped
  localparam row_t ROWS [0:13] = '{'{8'h00, 32'hC01FFF00, RESP_OKAY},
    '{8'h04, 32'h00006000, RESP_OKAY}, '{8'h08, 32'h0A3C0603, RESP_OKAY},
    '{8'h0C, 32'h00000064, RESP_OKAY}, '{8'h10, 32'h02580064, RESP_OKAY},
    '{8'h14, 32'h100401F4, RESP_OKAY}, '{8'h18, 32'h00C841A0, RESP_OKAY},
    '{8'h1C, 32'h10040A8C, RESP_OKAY}, '{8'h20, 32'h00150001, RESP_OKAY},
    '{8'h24, 32'h003D0029, RESP_OKAY}, '{8'h28, 32'hAE000051, RESP_OKAY},
    '{8'h2C, 32'h00000001, RESP_OKAY}, '{8'h34, 32'h00000000, RESP_OKAY},
    '{8'h3C, 32'h00000000, RESP_SLVERR}};
  // short hold so the display window fits a quick run
  battery_pin_io_control #(.HOLD_CYCLES(16)) dut (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe(pin_oe), .period_tick(period_tick), .trip_raw(trip_raw),
    .charge_alarm_set(charge_alarm_set), .charging(1'h0), .charge_req(1'h0), .ext_cond(4'h0),
    .meas(meas), .irq(irq));
  battery_pin_far_side far (.pin_o(pin_o), .pin_oe(pin_oe), .press(press), .pin_i(pin_i));
  // ----------------------------------------------------------------
  // clock, time base and shared tasks
  // ----------------------------------------------------------------
  always #4 aclk = ~aclk;
  // a tick every second cycle, so filters and extensions are not one-cycle
  always @(posedge aclk) period_tick <= ~period_tick;
  task automatic test_done;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  // sample at the falling edge, act just after the rising edge of the handshake
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    tb = 1'h0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid & awready; tw = wvalid & wready; tb = bvalid & bready; r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (tb) bready <= 1'h0;
    end
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    tr = 1'h0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid & arready; tr = rvalid & rready; d = rdata; r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'h0;
      if (tr) rready <= 1'h0;
    end
  endtask : rd_reg
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, period_tick, press} = '0;
    {awaddr, araddr, wdata, wstrb, trip_raw} = '0;
    ce = 1'h1;
    charge_alarm_set = 1'h0;
    meas = '{16'h00C8, 16'h012C, 16'h0000, 16'h0BB8, 16'h2710, 16'h0BB8};
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk(pin_o, 8'h00, "power-up level");
    chk(pin_oe, 8'hFF, "reset direction");
    @(posedge aclk) aresetn <= 1'h1;
    repeat (3) @(negedge aclk);
    chk(pin_o, 8'h3F, "idle levels");
    foreach (ROWS[i]) begin
      rd_reg(ROWS[i].a, rd, rs);
      chk(rd, ROWS[i].d, "reset register");
      chk(rs, ROWS[i].r, "read response");
    end
    wr_reg(8'h3C, 32'hFFFFFFFF, rs);
    chk(rs, RESP_SLVERR, "unmapped write");
    // pin 4 becomes a falling-edge switch input, pin 0 a display led; start unmasked
    wr_reg(OFS_PIN_CFG, 32'hC01FEF01, rs);
    wr_reg(OFS_PIN_ASG, 32'h00106000, rs);
    wr_reg(OFS_MASK, 32'h00000100, rs);
    chk(pin_oe, 8'hEF, "switch pin released");
    @(posedge aclk) press <= 1'h1;
    repeat (3) @(posedge aclk);
    press <= 1'h0;
    rd_reg(OFS_PINSTAT, rd, rs);
    chk(rd[16], 1'h1, "display started");
    chk(irq, 1'h1, "display interrupt");
    repeat (4) @(posedge aclk);
    press <= 1'h1;
    repeat (3) @(posedge aclk);
    press <= 1'h0;
    repeat (3) @(posedge aclk);
    rd_reg(OFS_PINSTAT, rd, rs);
    chk(rd[16], 1'h1, "display still on");
    repeat (16) @(posedge aclk);
    rd_reg(OFS_PINSTAT, rd, rs);
    chk(rd[16], 1'h0, "press during display ignored");
    wr_reg(OFS_STATUS, 32'h00000100, rs);
    @(negedge aclk);
    chk(irq, 1'h0, "status cleared");
    // imbalance trip must persist for the voltage filter, then clear on level
    @(posedge aclk) trip_raw <= 7'h0B;
    repeat (8) @(negedge aclk);
    chk(pin_o[6], 1'h0, "short trip filtered");
    repeat (20) @(negedge aclk);
    chk(pin_o[6], 1'h1, "safety pin active high");
    chk(pin_o[5], 1'h0, "safety pin active low");
    @(posedge aclk) trip_raw <= 7'h00;
    repeat (4) @(negedge aclk);
    chk(pin_o[6], 1'h1, "fault held above level");
    @(posedge aclk) meas.imbalance <= 16'h0032;
    repeat (4) @(negedge aclk);
    chk(pin_o[6], 1'h0, "fault cleared");
    // frozen block: a held trip must not advance the filter
    @(posedge aclk) ce <= 1'h0;
    meas.imbalance <= 16'h00C8;
    trip_raw <= 7'h01;
    repeat (30) @(negedge aclk);
    chk(pin_o[6], 1'h0, "trip counted while frozen");
    @(posedge aclk) ce <= 1'h1;
    trip_raw <= 7'h00;
    // alarm set with cell voltage above its clear level, then waits for cell voltage to fall
    @(posedge aclk) charge_alarm_set <= 1'h1;
    meas.cell_max <= 16'h1100;
    @(posedge aclk) charge_alarm_set <= 1'h0;
    rd_reg(OFS_PINSTAT, rd, rs);
    chk(rd[31], 1'h1, "alarm held above level");
    @(posedge aclk) meas.cell_max <= 16'h0BB8;
    rd_reg(OFS_PINSTAT, rd, rs);
    chk(rd[31], 1'h0, "alarm cleared at level");
    // reset in mid-run restores power-up level and direction
    @(posedge aclk) aresetn <= 1'h0;
    @(posedge aclk) aresetn <= 1'h1;
    @(negedge aclk);
    chk(pin_o, 8'h00, "power-up level after reset");
    chk(pin_oe, 8'hFF, "direction after reset");
    test_done();
  end
  // the run needs well under a thousand cycles
  initial begin
    #(8 * 3000);
    error_cnt++;
    test_done();
  end
endmodule : battery_pin_io_control_bench
